// *** assc_ctrl.sv ***
// Purpose: slot sequence controller sharing one converter among channels
// Assumes: Avalon-MM slave, one wait state on reads, no wait on writes
// Notes: converter handshake is start / busy / raw data
//
// Implementation choices: the address map and register access over Avalon-MM.
module assc_ctrl (
  input wire logic sys_clk, // 25 MHz system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic [5:0] avs_address, // word address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic manual_step_select, // 1: manual stepping
  input wire logic step_pulse, // manual step trigger
  input wire logic branch_request, // jump request
  input wire logic [5:0] target_slot_in, // jump target slot
  output logic [5:0] slot_out, // current slot
  output logic slot_done, // slot finished pulse
  output logic sample_active, // sample running
  output logic [4:0] conv_channel, // channel being converted
  output logic conv_start, // converter start pulse
  output logic conv_calibrate, // calibrate request level
  output logic conv_powerdown, // converter power-down level
  input wire logic conv_busy, // converter busy
  input wire logic [11:0] conv_raw, // raw converter data
  output logic [11:0] conversion_result_port, // aligned result
  output logic result_valid // result update pulse
);
  typedef enum logic [2:0] {S_FETCH, S_EXEC, S_CONV, S_CAL, S_DONE, S_HALT} assc_st_t;

  typedef assc_pkg::assc_slot_t assc_slot_t;

  logic [13:0] slot_mem [0:assc_pkg::SLOT_COUNT-1];
  logic [13:0] slot_rd;
  assc_slot_t cur;

  logic ms1_q, ms2_q, sp1_q, sp2_q, sp3_q, br1_q, br2_q;
  logic [5:0] tg1_q, tg2_q;
  logic [11:0] raw1_q, raw2_q;
  logic bz1_q, bz2_q;

  assc_st_t st_q, st_d;
  logic [5:0] slot_q, slot_d;
  logic [13:0] cnt_q, cnt_d;
  logic pdown_q, pdown_d;
  logic start_q, start_d;
  logic done_q, done_d;
  logic [4:0] chan_q, chan_d;
  logic [11:0] res_q, res_d;
  logic rv_q, rv_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic rdv_q, rdv_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] div_q, div_d;
  logic conv_tick;

  // drop low bits as resolution requires
  function automatic logic [11:0] align_res(input logic [11:0] raw, input logic [1:0] res);
    logic [11:0] v;
    v = raw;
    if (res == assc_pkg::ASSC_RES_10) begin
      v = {raw[11:2], 2'h0};
    end else if (res == assc_pkg::ASSC_RES_8) begin
      v = {raw[11:4], 4'h0};
    end
    return v;
  endfunction

  function automatic logic [5:0] next_slot(input logic [5:0] s);
    return (s == assc_pkg::LAST_SLOT) ? assc_pkg::MAIN_START : s + 6'h01;
  endfunction

  assign slot_rd = slot_mem[slot_q];
  assign cur = assc_slot_t'(slot_rd);
  assign conv_tick = (div_q == 2'(assc_pkg::CONV_DIV - 1));
  wire logic step_rise = sp2_q & ~sp3_q;
  wire logic go = ms2_q ? step_rise : ctrl_q[assc_pkg::CTRL_RUN_BIT];

  always_ff @(posedge sys_clk) begin
    ms1_q <= manual_step_select;
    ms2_q <= ms1_q;
    sp1_q <= step_pulse;
    sp2_q <= sp1_q;
    sp3_q <= sp2_q;
    br1_q <= branch_request;
    br2_q <= br1_q;
    tg1_q <= target_slot_in;
    tg2_q <= tg1_q;
    raw1_q <= conv_raw;
    raw2_q <= raw1_q;
    bz1_q <= conv_busy;
    bz2_q <= bz1_q;
  end

  always_ff @(posedge sys_clk) begin
    if (avs_write && avs_address >= assc_pkg::ADDR_SLOT_BASE[7:2]) begin
      slot_mem[avs_address - assc_pkg::ADDR_SLOT_BASE[7:2] + 6'h00] <= avs_writedata[13:0];
    end
  end

  always_comb begin
    st_d = st_q;
    slot_d = slot_q;
    cnt_d = cnt_q;
    pdown_d = pdown_q;
    start_d = 1'b0;
    done_d = 1'b0;
    chan_d = chan_q;
    res_d = res_q;
    rv_d = 1'b0;
    div_d = conv_tick ? 2'h0 : div_q + 2'h1;
    case (st_q)
      S_FETCH: begin
        if (go) begin
          st_d = S_EXEC;
        end
      end
      S_EXEC: begin
        chan_d = cur.chan;
        cnt_d = 14'h0000;
        case (cur.op)
          assc_pkg::ASSC_OP_SAMPLE, assc_pkg::ASSC_OP_SAMPLE_BR: begin
            if (pdown_q) begin
              st_d = S_DONE;
            end else begin
              start_d = 1'b1;
              st_d = S_CONV;
            end
          end
          assc_pkg::ASSC_OP_CAL, assc_pkg::ASSC_OP_CAL_BR: begin
            pdown_d = 1'b0;
            st_d = S_CAL;
          end
          assc_pkg::ASSC_OP_PDOWN: begin
            pdown_d = 1'b1;
            done_d = 1'b1;
            st_d = S_HALT;
          end
          assc_pkg::ASSC_OP_STOP: begin
            done_d = 1'b1;
            st_d = S_HALT;
          end
          default: st_d = S_DONE;
        endcase
      end
      S_CONV: begin
        if (conv_tick) begin
          cnt_d = cnt_q + 14'h0001;
        end
        if (cnt_q >= 14'(assc_pkg::SAMPLE_CLOCKS) && !bz2_q) begin
          res_d = align_res(raw2_q, ctrl_q[1:0]);
          rv_d = 1'b1;
          st_d = S_DONE;
        end
      end
      S_CAL: begin
        if (cnt_q == 14'(assc_pkg::CAL_CYCLES - 1)) begin
          st_d = S_DONE;
        end else begin
          cnt_d = cnt_q + 14'h0001;
        end
      end
      S_DONE: begin
        done_d = 1'b1;
        st_d = S_FETCH;
        if (br2_q) begin
          slot_d = tg2_q;
        end else if (cur.op == assc_pkg::ASSC_OP_SAMPLE_BR || cur.op == assc_pkg::ASSC_OP_CAL_BR
                     || cur.op == assc_pkg::ASSC_OP_BRANCH) begin
          slot_d = cur.target;
        end else begin
          slot_d = next_slot(slot_q);
        end
      end
      default: begin
        if (br2_q) begin
          slot_d = tg2_q;
          st_d = S_FETCH;
        end else if (ms2_q && step_rise) begin
          slot_d = next_slot(slot_q);
          st_d = S_FETCH;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q <= S_FETCH;
      slot_q <= assc_pkg::MAIN_START;
      cnt_q <= 14'h0000;
      pdown_q <= 1'b0;
      start_q <= 1'b0;
      done_q <= 1'b0;
      chan_q <= 5'h00;
      res_q <= 12'h000;
      rv_q <= 1'b0;
      div_q <= 2'h0;
    end else begin
      st_q <= st_d;
      slot_q <= slot_d;
      cnt_q <= cnt_d;
      pdown_q <= pdown_d;
      start_q <= start_d;
      done_q <= done_d;
      chan_q <= chan_d;
      res_q <= res_d;
      rv_q <= rv_d;
      div_q <= div_d;
    end
  end

  // register bus: writes land at once, reads answer one cycle later
  always_comb begin
    ctrl_d = ctrl_q;
    rdv_d = avs_read && !rdv_q;
    rdata_d = rdata_q;
    if (avs_write && avs_address == assc_pkg::ADDR_CTRL[7:2]) begin
      ctrl_d = avs_writedata[2:0];
    end
    if (avs_read && !rdv_q) begin
      if (avs_address == assc_pkg::ADDR_CTRL[7:2]) begin
        rdata_d = {29'h0, ctrl_q};
      end else if (avs_address == assc_pkg::ADDR_STATUS[7:2]) begin
        rdata_d = {22'h0, pdown_q, st_q, slot_q};
      end else if (avs_address == assc_pkg::ADDR_RESULT[7:2]) begin
        rdata_d = {20'h0, res_q};
      end else if (avs_address >= assc_pkg::ADDR_SLOT_BASE[7:2]) begin
        rdata_d = {18'h0, slot_mem[avs_address - assc_pkg::ADDR_SLOT_BASE[7:2] + 6'h00]};
      end else begin
        rdata_d = assc_pkg::UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_q <= assc_pkg::CTRL_RESET;
      rdv_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ctrl_q <= ctrl_d;
      rdv_q <= rdv_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest = avs_read && !rdv_q;
  assign avs_readdata = rdata_q;
  assign slot_out = slot_q;
  assign slot_done = done_q;
  assign sample_active = (st_q == S_CONV);
  assign conv_channel = chan_q;
  assign conv_start = start_q;
  assign conv_calibrate = (st_q == S_CAL);
  assign conv_powerdown = pdown_q;
  assign conversion_result_port = res_q;
  assign result_valid = rv_q;

  a_slot_done_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
    slot_done |=> !slot_done) else $error("slot done longer than one cycle");
  a_reset_slot_zero: assert property (@(posedge sys_clk)
    !reset_n |=> slot_out == 6'h00) else $error("slot not zero after reset");
  a_res_ten_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (result_valid && ctrl_q[1:0] == 2'h1) |-> conversion_result_port[1:0] == 2'h0)
    else $error("ten bit low bits not zero");
  a_res_eight_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (result_valid && ctrl_q[1:0] == 2'h2) |-> conversion_result_port[3:0] == 4'h0)
    else $error("eight bit low bits not zero");
  a_pdown_no_sample: assert property (@(posedge sys_clk) disable iff (!reset_n)
    conv_powerdown |-> !conv_start) else $error("sample while powered down");
  a_cal_length: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(conv_calibrate) |-> conv_calibrate [*8]) else $error("calibration too short");
  a_wrap_to_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_q == S_DONE && !br2_q && cur.op == assc_pkg::ASSC_OP_IDLE && slot_q == 6'h3F)
    |=> slot_out == 6'h00) else $error("no wrap at last slot");
  a_branch_target: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_q == S_DONE && br2_q) |=> slot_out == $past(tg2_q)) else $error("jump missed");
  a_stop_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_q == S_HALT && !br2_q && !(ms2_q && step_rise)) |=> st_q == S_HALT)
    else $error("halt left without trigger");
endmodule

// *** assc_pkg.sv ***
// Purpose: constants and types for the slot sequence controller
// Assumes: 25 MHz system clock, converter clocked by a divider enable
// Notes: slot encoding and register map are local choices
package assc_pkg;
  localparam int unsigned SLOT_COUNT = 64;
  localparam int unsigned CHAN_COUNT = 30;
  localparam int unsigned RES_W = 12;
  localparam int unsigned CONV_DIV = 4;
  localparam int unsigned CAL_CLOCKS = 3840;
  localparam int unsigned CAL_CYCLES = CAL_CLOCKS * CONV_DIV;
  localparam int unsigned SAMPLE_CLOCKS = 16;
  localparam logic [5:0] MAIN_START = 6'h00;
  localparam logic [5:0] LAST_SLOT = 6'h3F;
  // register map, word addresses in bytes
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_SLOT_BASE = 8'h80;
  localparam int unsigned CTRL_RES_LSB = 0;
  localparam int unsigned CTRL_RUN_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

  typedef enum logic [2:0] {
    ASSC_OP_IDLE, ASSC_OP_SAMPLE, ASSC_OP_SAMPLE_BR, ASSC_OP_CAL,
    ASSC_OP_CAL_BR, ASSC_OP_BRANCH, ASSC_OP_PDOWN, ASSC_OP_STOP
  } assc_op_t;

  typedef enum logic [1:0] {
    ASSC_RES_12, ASSC_RES_10, ASSC_RES_8, ASSC_RES_RSV
  } assc_res_t;

  // slot word: [13:11] op, [10:6] channel, [5:0] target
  typedef struct packed {
    assc_op_t op;
    logic [4:0] chan;
    logic [5:0] target;
  } assc_slot_t;

  typedef struct packed {
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } assc_bus_req_t;
endpackage

// *** assc_user_model.sv ***
// Purpose: user logic and converter model beside the slot sequencer
// Assumes: bench requests steps and jumps through go_step and go_jump
// Notes: converter stays busy 70 clocks per start; released lines do not hold
module assc_user_model (
  input wire logic sys_clk, // system clock
  input wire logic go_step, // bench asks for one manual step
  input wire logic go_jump, // bench asks for a jump
  input wire logic [5:0] jump_to, // procedure start slot
  input wire logic [5:0] slot_out, // current slot from the sequencer
  input wire logic conv_start, // converter start pulse
  output logic step_pulse, // manual step trigger
  output logic branch_request, // jump request
  output logic [5:0] target_slot_in, // jump target slot
  output logic conv_busy, // converter busy
  output logic [11:0] conv_raw // raw converter data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] busy_n;
  logic [3:0] held;
  initial begin
    busy_n = 7'h00;
    held = 4'h0;
    step_pulse = 1'b0;
    branch_request = 1'b0;
    target_slot_in = 6'h00;
  end
  assign conv_busy = busy_n != 7'h00;
  // data lines show the inverse while the conversion runs
  assign conv_raw = conv_busy ? 12'hA58 : 12'h5A7;
  always @(posedge sys_clk) begin
    step_pulse <= go_step;
    held <= go_jump ? ((held != 4'hF) ? held + 4'h1 : held) : 4'h0;
    branch_request <= go_jump && !(held == 4'hF && slot_out == jump_to);
    if (go_jump)
      target_slot_in <= jump_to;
    else if (!branch_request)
      target_slot_in <= ~target_slot_in;
    busy_n <= conv_start ? 7'h46 : (conv_busy ? busy_n - 7'h01 : busy_n);
  end
endmodule

// *** testbench.sv ***
// Purpose: self-checking bench for the slot sequence controller
// Assumes: monitor samples on the falling edge, bus samples on the rising edge and drives after it
// Notes: wrap from slot 63 is out of bus reach and not exercised
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest, manual_step_select;
  logic step_pulse, branch_request, slot_done, sample_active, conv_start, conv_calibrate;
  logic conv_powerdown, conv_busy, result_valid, go_step, go_jump;
  logic [5:0] avs_address, target_slot_in, slot_out, jump_to, last;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [4:0] conv_channel;
  logic [11:0] conv_raw, conversion_result_port;
  logic [11:0] visits[$], chans[$], results[$];
  int fails, n_tests, cal_n, cal_len;
  // slot word {op, channel, target}; every procedure ends terminated
  localparam logic [13:0] PROG [15] = '{14'h08C0, 14'h0000, 14'h11C4, 14'h3800, 14'h2806,
    14'h3800, 14'h3000, 14'h3800, 14'h0A40, 14'h200C, 14'h3800, 14'h3800, 14'h1800,
    14'h0F40, 14'h3800};
  assc_ctrl assc_ctrl_inst (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .manual_step_select, .step_pulse,
    .branch_request, .target_slot_in, .slot_out, .slot_done, .sample_active, .conv_channel,
    .conv_start, .conv_calibrate, .conv_powerdown, .conv_busy, .conv_raw,
    .conversion_result_port, .result_valid);
  assc_user_model assc_user_model_inst (.sys_clk, .go_step, .go_jump, .jump_to, .slot_out,
    .conv_start, .step_pulse, .branch_request, .target_slot_in, .conv_busy, .conv_raw);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    last <= slot_out;
    if (slot_out !== last) visits.push_back({6'h00, slot_out});
    if (conv_start === 1'b1) chans.push_back({7'h00, conv_channel});
    if (result_valid === 1'b1) results.push_back(conversion_result_port);
    if (conv_calibrate === 1'b1) cal_n <= cal_n + 1;
    else if (cal_n != 0) begin
      cal_len <= cal_n;
      cal_n <= 0;
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    logic ok;
    ok = 1'b0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (int k = 0; k < 50 && !ok; k++) begin
      @(posedge sys_clk);
      ok = (avs_waitrequest === 1'b0);
      q = avs_readdata;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
    if (!ok) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic wait_slot(input logic [5:0] s);
    for (int k = 0; k < 40000 && slot_out !== s; k++) @(negedge sys_clk);
    if (slot_out !== s) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic jump(input logic [5:0] s, input logic clr);
    jump_to <= s;
    go_jump <= 1'b1;
    wait_slot(s);
    if (clr) begin
      visits.delete();
      chans.delete();
      results.delete();
    end
    repeat (20) @(posedge sys_clk);
    go_jump <= 1'b0;
  endtask
  task automatic step();
    int k;
    go_step <= 1'b1;
    @(posedge sys_clk);
    go_step <= 1'b0;
    for (k = 0; k < 400 && slot_done !== 1'b1; k++) @(negedge sys_clk);
    chk("slot_done", 32'h1, {31'h0, slot_done});
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic cmpq(input string nm, input logic [11:0] e[$], input logic [11:0] g[$]);
    chk(nm, e.size(), g.size());
    foreach (e[i]) if (i < g.size()) chk(nm, {20'h0, e[i]}, {20'h0, g[i]});
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    give_verdict();
  end
  initial begin
    {reset_n, avs_read, avs_write, manual_step_select, go_step, go_jump} = 6'h00;
    {avs_address, jump_to, avs_writedata, cal_n, cal_len, fails, n_tests} = '0;
    repeat (3) @(posedge sys_clk);
    chk("slot_reset", 32'h0, {26'h0, slot_out});
    reset_n <= 1'b1;
    bus(1'b0, 6'h00, 32'h0);
    chk("ctrl_reset", 32'h4, q);
    bus(1'b1, 6'h00, 32'h0);
    foreach (PROG[n]) bus(1'b1, 6'h20 + 6'(n), {18'h0, PROG[n]});
    foreach (PROG[n]) begin
      bus(1'b0, 6'h20 + 6'(n), 32'h0);
      chk("slot_word", {18'h0, PROG[n]}, q);
    end
    bus(1'b1, 6'h03, 32'hFFFF);
    bus(1'b0, 6'h03, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, 6'h00, 32'h4);
    jump(6'h00, 1'b1);
    wait_slot(6'h06);
    repeat (300) @(posedge sys_clk);
    chk("pdown_halt", 32'h6, {26'h0, slot_out});
    chk("pdown_lvl", 32'h1, {31'h0, conv_powerdown});
    jump(6'h08, 1'b0);
    wait_slot(6'h0E);
    repeat (300) @(posedge sys_clk);
    chk("stop_halt", 32'hE, {26'h0, slot_out});
    chk("sample_idle", 32'h0, {31'h0, sample_active});
    chk("pdown_lvl", 32'h0, {31'h0, conv_powerdown});
    chk("cal_len", assc_pkg::CAL_CYCLES, cal_len);
    bus(1'b0, 6'h01, 32'h0);
    chk("status_slot", 32'hE, {26'h0, q[5:0]});
    if (visits.size() != 0 && visits[0] === 12'h000) visits.pop_front();
    cmpq("visits", {12'h1, 12'h2, 12'h4, 12'h6, 12'h8, 12'h9, 12'hC, 12'hD, 12'hE}, visits);
    cmpq("chans", {12'h3, 12'h7, 12'h1D}, chans);
    cmpq("res12", {12'h5A7, 12'h5A7, 12'h5A7}, results);
    bus(1'b0, 6'h02, 32'h0);
    chk("result_reg", 32'h5A7, q);
    manual_step_select <= 1'b1;
    bus(1'b1, 6'h00, 32'h5);
    jump(6'h00, 1'b1);
    step();
    chk("manual_slot", 32'h1, {26'h0, slot_out});
    bus(1'b1, 6'h00, 32'h6);
    step();
    step();
    chk("manual_slot", 32'h4, {26'h0, slot_out});
    cmpq("chans_m", {12'h3, 12'h7}, chans);
    cmpq("res_m", {12'h5A4, 12'h5A0}, results);
    give_verdict();
  end
endmodule
